//--- inc/nvmcs_regs.svh
`ifndef NVMCS_REGS_SVH
`define NVMCS_REGS_SVH
`define NVMCS_OFS_STAT   8'h00
`define NVMCS_OFS_CMD    8'h04
`define NVMCS_OFS_DIV    8'h08
`define NVMCS_OFS_ADDR   8'h0C
`define NVMCS_OFS_DATA   8'h10
`define NVMCS_OFS_IRQS   8'h14
`define NVMCS_OFS_IRQM   8'h18
`define NVMCS_BIT_CBE    7
`define NVMCS_BIT_CC     6
`define NVMCS_BIT_PV     5
`define NVMCS_BIT_AE     4
`define NVMCS_BIT_BLANK  2
`define NVMCS_IRQ_DONE   0
`define NVMCS_IRQ_PV     1
`define NVMCS_IRQ_AE     2
`define NVMCS_CMD_BLANK  8'h05
`define NVMCS_CMD_BYTE   8'h20
`define NVMCS_CMD_BURST  8'h25
`define NVMCS_CMD_SECT   8'h40
`define NVMCS_CMD_MASS   8'h41
`define NVMCS_CMD_ABORT  8'h47
`define NVMCS_RST_DIV    8'h00
`define NVMCS_RST_IRQM   3'h0
`define NVMCS_RST_CMD    8'h00
`endif

//--- inc/nvmcs_pkg.sv
package nvmcs_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_DATA = 3'b010,
    SEQ_CMD  = 3'b100
  } nvmcs_seq_t;
  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] addr;
    logic [7:0]  data;
  } nvmcs_req_t;
endpackage

//--- core/nvmcs_top.sv
`timescale 1ns/1ps
`include "nvmcs_regs.svh"
// Notes on behaviour
// - Writing one to bit 7 launches command
// - Buffer flag updates when burst reaches array
// - Only burst program may be buffered
// - Buffer flag one means burst may load
// - Complete flag sets when all idle
// - Valid launch clears complete flag; writes ignored
// - Protected program or erase ignored, flagged
// - Protection flag cleared by writing one
// - Broken write sequence flags access error
// - Program or erase before divider written errors
// - Stop during command flags access error
// - Access error cleared by writing one
// - Blank check result sets blank flag
// - Valid launch clears blank; writes ignored
// - Codes 0x05, 0x20, 0x25 recognised
// - Codes 0x40, 0x41, 0x47 recognised
// - Other codes are illegal, access error
module nvmcs_top
  import nvmcs_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        stop_entry,
  input  wire logic        cmd_protected,
  input  wire logic        array_done,
  input  wire logic        array_blank_ok,
  output logic             array_start,
  output nvmcs_req_t       array_req
);

  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        cbe_q;
  logic        cc_q;
  logic        pv_q;
  logic        ae_q;
  logic        blank_q;
  logic [7:0]  cmd_q;
  logic [15:0] addr_q;
  logic [7:0]  data_q;
  logic [7:0]  div_q;
  logic        div_set_q;
  nvmcs_seq_t  seq_q;
  logic        running_q;
  logic        run_burst_q;
  logic        buf_valid_q;
  nvmcs_req_t  buf_q;
  nvmcs_req_t  req_q;
  logic        start_q;
  logic        stop_q;
  logic [2:0]  irqs_q;
  logic [2:0]  irqm_q;
  logic        irq_q;

  logic        acc;
  logic        wr;
  logic        rd;
  logic [7:0]  wb;
  logic        wr_stat;
  logic        wr_cmd;
  logic        wr_arg;
  logic        launch;
  logic        legal;
  logic        is_pe;
  logic        burst_new;
  logic        ae_launch;
  logic        ae_seq;
  logic        ae_stop;
  logic        ae_set;
  logic        pv_set;
  logic        go;
  logic        start_new;
  logic        stop_rise;
  logic        cc_set;
  logic        mapped;
  logic [7:0]  stat_rd;
  nvmcs_req_t  new_req;

  // Bus strobes
  assign acc     = psel & penable & pready_q;
  assign wr      = acc & pwrite;
  assign rd      = acc & ~pwrite;
  assign wb      = pwdata[7:0];
  assign wr_stat = wr && (paddr == `NVMCS_OFS_STAT);
  assign wr_cmd  = wr && (paddr == `NVMCS_OFS_CMD);
  assign wr_arg  = wr && ((paddr == `NVMCS_OFS_ADDR) || (paddr == `NVMCS_OFS_DATA));
  assign launch  = wr_stat && wb[`NVMCS_BIT_CBE];

  // Command decode
  always_comb begin
    legal = 1'b0;
    is_pe = 1'b0;
    case (cmd_q)
      `NVMCS_CMD_BLANK: legal = 1'b1;
      `NVMCS_CMD_BYTE, `NVMCS_CMD_BURST: begin
        legal = 1'b1;
        is_pe = 1'b1;
      end
      `NVMCS_CMD_SECT, `NVMCS_CMD_MASS: begin
        legal = 1'b1;
        is_pe = 1'b1;
      end
      `NVMCS_CMD_ABORT: legal = 1'b1;
      default: legal = 1'b0;
    endcase
  end

  assign burst_new = (cmd_q == `NVMCS_CMD_BURST);
  assign new_req   = '{cmd: cmd_q, addr: addr_q, data: data_q};

  // Error and launch qualification
  assign ae_launch = launch && (!cbe_q || seq_q != SEQ_CMD
                   || !legal
                   || (is_pe && !div_set_q)
                   || (running_q && !(burst_new && run_burst_q)));
  assign ae_seq    = (wr_arg && !cbe_q) || (wr_cmd && (seq_q == SEQ_IDLE || !cbe_q));
  assign stop_rise = stop_entry && !stop_q;
  assign ae_stop   = stop_rise && (running_q || buf_valid_q);
  assign ae_set    = ae_launch || ae_seq || ae_stop;
  assign pv_set    = launch && !ae_launch && is_pe && cmd_protected;
  assign go        = launch && !ae_launch && !pv_set;
  assign start_new = go && (!running_q || (array_done && !buf_valid_q));
  assign cc_set    = !cc_q && !running_q && !buf_valid_q && !go;

  // APB answer, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= psel && penable && !pready_q;
    end
  end

  assign mapped  = (paddr <= `NVMCS_OFS_IRQM) && (paddr[1:0] == 2'b00);
  assign stat_rd = {cbe_q, cc_q, pv_q, ae_q, 1'b0, blank_q, 2'b00};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (psel && penable && !pready_q) begin
      pslverr_q <= !mapped;
      if (pwrite) begin
        prdata_q <= 32'h00000000;
      end else if (paddr == `NVMCS_OFS_STAT) begin
        prdata_q <= {24'h000000, stat_rd};
      end else if (paddr == `NVMCS_OFS_CMD) begin
        prdata_q <= {24'h000000, cmd_q};
      end else if (paddr == `NVMCS_OFS_DIV) begin
        prdata_q <= {24'h000000, div_q};
      end else if (paddr == `NVMCS_OFS_ADDR) begin
        prdata_q <= {16'h0000, addr_q};
      end else if (paddr == `NVMCS_OFS_DATA) begin
        prdata_q <= {24'h000000, data_q};
      end else if (paddr == `NVMCS_OFS_IRQS) begin
        prdata_q <= {29'h00000000, irqs_q};
      end else if (paddr == `NVMCS_OFS_IRQM) begin
        prdata_q <= {29'h00000000, irqm_q};
      end else begin
        prdata_q <= 32'h00000000;
      end
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  // Argument, command and divider registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q    <= 16'h0000;
      data_q    <= 8'h00;
      cmd_q     <= `NVMCS_RST_CMD;
      div_q     <= `NVMCS_RST_DIV;
      div_set_q <= 1'b0;
    end else begin
      if (wr && paddr == `NVMCS_OFS_ADDR && cbe_q) begin
        addr_q <= pwdata[15:0];
      end
      if (wr && paddr == `NVMCS_OFS_DATA && cbe_q) begin
        data_q <= wb;
      end
      if (wr_cmd && !ae_seq) begin
        cmd_q <= wb;
      end
      if (wr && paddr == `NVMCS_OFS_DIV) begin
        div_q     <= wb;
        div_set_q <= 1'b1;
      end
    end
  end

  // Write sequence tracker
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_q <= SEQ_IDLE;
    end else begin
      case (seq_q)
        SEQ_IDLE: if (wr_arg && cbe_q) seq_q <= SEQ_DATA;
        SEQ_DATA: if (wr_cmd && cbe_q) seq_q <= SEQ_CMD;
        SEQ_CMD:  if (launch || ae_seq) seq_q <= SEQ_IDLE;
        default:  seq_q <= SEQ_IDLE;
      endcase
    end
  end

  // Array hand-over and one-deep burst buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running_q   <= 1'b0;
      run_burst_q <= 1'b0;
      buf_valid_q <= 1'b0;
      buf_q       <= '0;
      req_q       <= '0;
      start_q     <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (start_new) begin
        start_q     <= 1'b1;
        req_q       <= new_req;
        running_q   <= 1'b1;
        run_burst_q <= burst_new;
      end else if (go) begin
        buf_valid_q <= 1'b1;
        buf_q       <= new_req;
      end else if (running_q && array_done) begin
        if (buf_valid_q) begin
          start_q     <= 1'b1;
          req_q       <= buf_q;
          buf_valid_q <= 1'b0;
        end else begin
          running_q   <= 1'b0;
          run_burst_q <= 1'b0;
        end
      end
    end
  end

  // Status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cbe_q <= 1'b1;
    end else if (go) begin
      cbe_q <= 1'b0;
    end else if ((start_q && run_burst_q && !buf_valid_q) || cc_set) begin
      cbe_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc_q <= 1'b1;
    end else if (go) begin
      cc_q <= 1'b0;
    end else if (cc_set) begin
      cc_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pv_q <= 1'b0;
      ae_q <= 1'b0;
    end else begin
      pv_q <= pv_set || (pv_q && !(wr_stat && wb[`NVMCS_BIT_PV]));
      ae_q <= ae_set || (ae_q && !(wr_stat && wb[`NVMCS_BIT_AE]));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_q <= 1'b0;
    end else if (go) begin
      blank_q <= 1'b0;
    end else if (running_q && array_done && req_q.cmd == `NVMCS_CMD_BLANK) begin
      blank_q <= array_blank_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_q <= 1'b0;
    end else begin
      stop_q <= stop_entry;
    end
  end

  // Interrupt status, mask and output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irqs_q <= 3'h0;
      irqm_q <= `NVMCS_RST_IRQM;
      irq_q  <= 1'b0;
    end else begin
      irqs_q <= {ae_set, pv_set, cc_set}
              | (irqs_q & ~{3{rd && paddr == `NVMCS_OFS_IRQS}});
      if (wr && paddr == `NVMCS_OFS_IRQM) begin
        irqm_q <= pwdata[2:0];
      end
      irq_q <= |(irqs_q & irqm_q);
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign irq         = irq_q;
  assign array_start = start_q;
  assign array_req   = req_q;

  // Checks
  a_launch_cbe_clr: assert property (@(posedge pclk) disable iff (!presetn)
    go |=> !cbe_q && (start_q || buf_valid_q))
    else $error("launch did not clear buffer flag");
  a_burst_handover: assert property (@(posedge pclk) disable iff (!presetn)
    start_q && run_burst_q && !buf_valid_q && !go |=> cbe_q)
    else $error("buffer flag not restored at burst hand-over");
  a_buf_burst_only: assert property (@(posedge pclk) disable iff (!presetn)
    buf_valid_q |-> run_burst_q && buf_q.cmd == `NVMCS_CMD_BURST)
    else $error("non-burst command buffered");
  a_busy_cbe_low: assert property (@(posedge pclk) disable iff (!presetn)
    running_q && !run_burst_q |-> !cbe_q)
    else $error("buffer flag high during non-burst command");
  a_cc_sets: assert property (@(posedge pclk) disable iff (!presetn)
    !running_q && !buf_valid_q && !go ##1 !running_q && !go |-> cc_q)
    else $error("complete flag not set when idle");
  a_cc_clears: assert property (@(posedge pclk) disable iff (!presetn)
    go |=> !cc_q ##1 !cc_q)
    else $error("complete flag not cleared by launch");
  a_pv_ignore: assert property (@(posedge pclk) disable iff (!presetn)
    pv_set |=> pv_q && !start_q && !$rose(running_q))
    else $error("protected command not ignored");
  a_pv_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    pv_q && !(wr_stat && wb[`NVMCS_BIT_PV]) |=> pv_q)
    else $error("protection flag lost");
  a_ae_nodiv: assert property (@(posedge pclk) disable iff (!presetn)
    launch && is_pe && !div_set_q |=> ae_q && !start_q)
    else $error("missing divider not flagged");
  a_ae_stop: assert property (@(posedge pclk) disable iff (!presetn)
    stop_entry && !$past(stop_entry) && running_q |=> ae_q)
    else $error("stop during command not flagged");
  a_ae_clear: assert property (@(posedge pclk) disable iff (!presetn)
    ae_q && wr_stat && !wb[`NVMCS_BIT_AE] |=> ae_q)
    else $error("zero write cleared access error");
  a_blank_result: assert property (@(posedge pclk) disable iff (!presetn)
    running_q && array_done && req_q.cmd == `NVMCS_CMD_BLANK && !go
    |=> blank_q == $past(array_blank_ok))
    else $error("blank result not captured");
  a_illegal_code: assert property (@(posedge pclk) disable iff (!presetn)
    launch && !legal |=> ae_q && !start_q)
    else $error("illegal code not flagged");
  a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready_q && !pwrite && paddr == `NVMCS_OFS_STAT |-> prdata_q[3] == 1'b0
    && prdata_q[1:0] == 2'b00)
    else $error("reserved status bits not zero");

endmodule

//--- sim/nvmcs_top_test.sv
`timescale 1ns/1ps
`include "nvmcs_regs.svh"
module nvmcs_top_test
  import nvmcs_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, err;
  logic        stop_entry, cmd_protected, array_done, array_blank_ok;
  logic [7:0]  paddr, c, ld;
  logic [15:0] la;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, irq, array_start, bl;
  nvmcs_req_t  array_req, last_req;
  int          failures, checks, starts, n0;
  logic [7:0]  codes [7] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41, 8'h47, 8'h05};

  nvmcs_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .stop_entry(stop_entry),
    .cmd_protected(cmd_protected), .array_done(array_done),
    .array_blank_ok(array_blank_ok), .array_start(array_start), .array_req(array_req));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Start pulse monitor
  always @(posedge pclk) begin
    if (array_start === 1'b1) begin
      starts++;
      last_req <= array_req;
    end
  end

  function automatic logic [31:0] stat(logic cbe, logic cc, logic pv, logic ae, logic b);
    return {24'h0, cbe, cc, pv, ae, 1'h0, b, 2'h0};
  endfunction

  function automatic bit legal(logic [7:0] k);
    foreach (codes[i]) if (codes[i] == k) return 1;
    return 0;
  endfunction

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(string nm, logic [7:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  task automatic launch(logic [7:0] k);
    la = 16'($urandom);
    ld = 8'($urandom);
    apb(1'b1, `NVMCS_OFS_ADDR, {16'h0, la});
    apb(1'b1, `NVMCS_OFS_DATA, {24'h0, ld});
    apb(1'b1, `NVMCS_OFS_CMD, {24'h0, k});
    apb(1'b1, `NVMCS_OFS_STAT, 32'h80);
    repeat (2) @(posedge pclk);
  endtask

  task automatic done(logic b);
    @(posedge pclk);
    array_done <= 1'b1;
    array_blank_ok <= b;
    @(posedge pclk);
    array_done <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    stop_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, stop_entry, cmd_protected} = '0;
    {array_done, array_blank_ok, paddr, pwdata} = '0;
    void'($urandom(30491));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk("status_reset", `NVMCS_OFS_STAT, 32'hC0);
    rchk("mask_reset", `NVMCS_OFS_IRQM, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    launch(`NVMCS_CMD_BYTE);
    rchk("no_divider", `NVMCS_OFS_STAT, stat(1, 1, 0, 1, 0));
    chk("no_divider_start", 32'h0, starts);
    apb(1'b1, `NVMCS_OFS_STAT, 32'h4F);
    rchk("ro_bits", `NVMCS_OFS_STAT, stat(1, 1, 0, 1, 0));
    apb(1'b1, `NVMCS_OFS_STAT, 32'h10);
    rchk("ae_clear", `NVMCS_OFS_STAT, 32'hC0);
    apb(1'b1, `NVMCS_OFS_DIV, 32'h13);
    apb(1'b1, `NVMCS_OFS_CMD, {24'h0, `NVMCS_CMD_BYTE});
    rchk("bad_order", `NVMCS_OFS_STAT, stat(1, 1, 0, 1, 0));
    for (int i = 0; i < 4; i++) begin
      c = 8'($urandom);
      while (legal(c)) c = 8'($urandom);
      apb(1'b1, `NVMCS_OFS_STAT, 32'h10);
      launch(c);
      rchk("illegal", `NVMCS_OFS_STAT, stat(1, 1, 0, 1, 0));
    end
    apb(1'b1, `NVMCS_OFS_STAT, 32'h10);
    chk("illegal_start", 32'h0, starts);
    foreach (codes[i]) begin
      bl = (i == 0) ? 1'b1 : 1'($urandom);
      n0 = starts;
      launch(codes[i]);
      chk("start_cnt", n0 + 1, starts);
      chk("req_cmd", {24'h0, codes[i]}, {24'h0, last_req.cmd});
      chk("req_arg", {8'h0, la, ld}, {8'h0, last_req.addr, last_req.data});
      rchk("busy", `NVMCS_OFS_STAT, stat(codes[i] == 8'h25, 0, 0, 0, 0));
      done(bl);
      rchk("finish", `NVMCS_OFS_STAT, stat(1, 1, 0, 0, codes[i] == 8'h05 && bl));
    end
    cmd_protected <= 1'b1;
    n0 = starts;
    launch(`NVMCS_CMD_SECT);
    chk("prot_start", n0, starts);
    apb(1'b1, `NVMCS_OFS_STAT, 32'h10);
    rchk("prot_flag", `NVMCS_OFS_STAT, stat(1, 1, 1, 0, 0));
    apb(1'b1, `NVMCS_OFS_STAT, 32'h20);
    rchk("prot_clear", `NVMCS_OFS_STAT, 32'hC0);
    cmd_protected <= 1'b0;
    n0 = starts;
    launch(`NVMCS_CMD_BURST);
    rchk("burst1", `NVMCS_OFS_STAT, stat(1, 0, 0, 0, 0));
    launch(`NVMCS_CMD_BYTE);
    rchk("busy_byte0", `NVMCS_OFS_STAT, stat(1, 0, 0, 1, 0));
    apb(1'b1, `NVMCS_OFS_STAT, 32'h10);
    launch(`NVMCS_CMD_BURST);
    rchk("burst2", `NVMCS_OFS_STAT, stat(0, 0, 0, 0, 0));
    launch(`NVMCS_CMD_BYTE);
    rchk("busy_byte", `NVMCS_OFS_STAT, stat(0, 0, 0, 1, 0));
    chk("buffered", n0 + 1, starts);
    done(1'b0);
    chk("handover", n0 + 2, starts);
    rchk("burst3", `NVMCS_OFS_STAT, stat(1, 0, 0, 1, 0));
    done(1'b0);
    rchk("burst_end", `NVMCS_OFS_STAT, stat(1, 1, 0, 1, 0));
    apb(1'b1, `NVMCS_OFS_STAT, 32'h10);
    launch(`NVMCS_CMD_SECT);
    stop_entry <= 1'b1;
    @(posedge pclk);
    stop_entry <= 1'b0;
    rchk("stop", `NVMCS_OFS_STAT, stat(0, 0, 0, 1, 0));
    done(1'b0);
    apb(1'b1, `NVMCS_OFS_STAT, 32'h10);
    apb(1'b0, `NVMCS_OFS_IRQS, 32'h0);
    apb(1'b1, `NVMCS_OFS_IRQM, 32'h1);
    launch(`NVMCS_CMD_MASS);
    done(1'b0);
    chk("irq_on", 32'h1, {31'h0, irq});
    rchk("irq_stat", `NVMCS_OFS_IRQS, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_off", 32'h0, {31'h0, irq});
    launch(8'hFF);
    repeat (3) @(posedge pclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rchk("irq_ae", `NVMCS_OFS_IRQS, 32'h4);
    stop_test();
  end
endmodule
